// [rspc_pkg.sv]
// Package of constants and types for the reset and sleep power control block
package rspc_pkg;
    // Register offsets of the plain register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DIGITAL_INPUT_DISABLE_0 = 4'h1;
    localparam logic [3:0] ADDR_DIGITAL_INPUT_DISABLE_1 = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_SLEEP = 4'h4;
    // Control register fields
    localparam int CTRL_DBG_DIS_BIT = 7;
    localparam int CTRL_USB_RST_EN_BIT = 0;
    localparam int CTRL_ACBG_BIT = 1;
    localparam int CTRL_ADC_EN_BIT = 2;
    localparam int CTRL_AC_EN_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIDR_RESET = 8'h00;
    // Sleep register fields
    localparam int SLEEP_ACT_BIT = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam logic [3:0] SLEEP_RESET = 4'h0;
    // Sleep mode codes
    typedef enum logic [2:0] {
        RSPC_SM_IDLE = 3'b000,
        RSPC_SM_ADCNR = 3'b001,
        RSPC_SM_PDOWN = 3'b010,
        RSPC_SM_PSAVE = 3'b011,
        RSPC_SM_RSV4 = 3'b100,
        RSPC_SM_RSV5 = 3'b101,
        RSPC_SM_STBY = 3'b110,
        RSPC_SM_XSTBY = 3'b111
    } rspc_sleep_mode_t;
    // Brown-out level setting that disables the detector
    localparam logic [2:0] BOD_LEVEL_OFF = 3'b111;
    // Clock period and external reset pulse width
    localparam int CLK_PERIOD_PS = 4000;
    localparam int EXT_RST_MIN_PS = 400000;
    localparam logic [7:0] EXT_RST_CYCLES = 8'((EXT_RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // Reset stretch delays in cycles, indexed by startup time select
    localparam logic [19:0] DLY_SHORT = 20'h00010;
    localparam logic [19:0] DLY_MID = 20'h01000;
    localparam logic [19:0] DLY_LONG = 20'h10000;
    localparam logic [19:0] DLY_XLONG = 20'h40000;
    // Release state machine
    typedef enum logic [1:0] {
        RSPC_ST_HOLD = 2'b00,
        RSPC_ST_COUNT = 2'b01,
        RSPC_ST_RUN = 2'b10
    } rspc_state_t;
endpackage : rspc_pkg

// [rspc_sync.sv]
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module rspc_sync
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic rst_val_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= 1'b1;
            q_out <= 1'b1;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
    // rst_val_in is kept only for a uniform port list; the reset value is always one
    logic unused_w;
    assign unused_w = rst_val_in;
endmodule : rspc_sync

// [rspc_core.sv]
// Reset combiner, reset stretch and sleep power gating
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module rspc_core
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic por_low_in,
    input wire logic ext_rst_n_in,
    input wire logic wdt_expire_in,
    input wire logic wdt_enable_in,
    input wire logic bod_low_in,
    input wire logic dbg_rst_bit_in,
    input wire logic usb_eor_in,
    input wire logic [2:0] brownout_level_setting_in,
    input wire logic [1:0] startup_time_select_in,
    input wire logic [3:0] clock_source_select_in,
    input wire logic onchip_debug_enable_setting_in,
    input wire logic debug_port_enable_setting_in,
    input wire logic [7:0] wake_pin_mask_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic port_rst_out,
    output logic core_rst_out,
    output logic usb_rst_out,
    output logic fetch_vector_out,
    output logic ac_enable_out,
    output logic vref_enable_out,
    output logic bod_active_out,
    output logic wdt_run_out,
    output logic main_clk_en_out,
    output logic onchip_debug_system_en_out,
    output logic [7:0] pin_ibuf_en_out,
    output logic [7:0] ain_ibuf_en_out
);
    typedef struct packed {
        rspc_pkg::rspc_state_t st;
        logic [19:0] cnt;
        logic [7:0] ext_cnt;
        logic ext_req;
        logic usb_only;
        logic [7:0] ctrl;
        logic [7:0] digital_input_disable_0;
        logic [7:0] digital_input_disable_1;
        logic [3:0] sleep;
        logic [7:0] rdata;
        logic core_rst;
        logic usb_rst;
        logic fetch;
        logic ac_en;
        logic vref_en;
        logic bod_act;
        logic wdt_run;
        logic clk_en;
        logic dbg_en;
        logic [7:0] pin_en;
        logic [7:0] ain_en;
    } rspc_core_state_t;

    rspc_core_state_t s_reg;
    rspc_core_state_t s_next;
    logic any_async_req;
    logic rst_pin_low_w;
    logic por_sync_w;
    logic wdt_sync_w;
    logic bod_sync_w;
    logic dbg_sync_w;
    logic usb_sync_w;
    logic bod_enabled_w;
    logic port_rst_a_reg;
    logic port_rst_b_reg;

    assign bod_enabled_w = (brownout_level_setting_in != rspc_pkg::BOD_LEVEL_OFF);
    // Asynchronous level requests, reach the pins without a clock
    assign any_async_req = por_low_in | ~ext_rst_n_in | (bod_low_in & bod_enabled_w)
        | dbg_rst_bit_in | rst_in;

    // Port reset: set asynchronously, released on the clock
    always_ff @(posedge mclk_in or posedge any_async_req)
    begin
        if (any_async_req)
        begin
            port_rst_a_reg <= 1'b1;
            port_rst_b_reg <= 1'b1;
        end
        else
        begin
            port_rst_a_reg <= s_reg.core_rst & ~s_reg.usb_only;
            port_rst_b_reg <= port_rst_a_reg;
        end
    end
    assign port_rst_out = port_rst_b_reg;

    rspc_sync u_sync_por (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(por_low_in), .q_out(por_sync_w));
    rspc_sync u_sync_ext (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(~ext_rst_n_in), .q_out(rst_pin_low_w));
    rspc_sync u_sync_wdt (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(wdt_expire_in & wdt_enable_in), .q_out(wdt_sync_w));
    rspc_sync u_sync_bod (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(bod_low_in & bod_enabled_w), .q_out(bod_sync_w));
    rspc_sync u_sync_dbg (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(dbg_rst_bit_in), .q_out(dbg_sync_w));
    rspc_sync u_sync_usb (.mclk_in(mclk_in), .rst_in(rst_in), .rst_val_in(1'b1),
        .d_in(usb_eor_in), .q_out(usb_sync_w));

    always_comb
    begin
        logic [19:0] dly;
        logic full_req;
        logic usb_req;
        logic deep;
        logic [2:0] mode;
        logic asleep;
        dly = rspc_pkg::DLY_SHORT;
        full_req = 1'b0;
        usb_req = 1'b0;
        deep = 1'b0;
        mode = 3'b000;
        asleep = 1'b0;
        s_next = s_reg;
        // Stretch length from startup time select; forced to DLY_SHORT when clock source select bit 3 is zero
        case (startup_time_select_in)
            2'b00: dly = rspc_pkg::DLY_SHORT;
            2'b01: dly = rspc_pkg::DLY_MID;
            2'b10: dly = rspc_pkg::DLY_LONG;
            2'b11: dly = rspc_pkg::DLY_XLONG;
            default: dly = rspc_pkg::DLY_SHORT;
        endcase
        if (clock_source_select_in[3] == 1'b0)
        begin
            dly = rspc_pkg::DLY_SHORT;
        end
        // External pin low must persist for the minimum width
        if (rst_pin_low_w)
        begin
            if (s_reg.ext_cnt != rspc_pkg::EXT_RST_CYCLES)
            begin
                s_next.ext_cnt = s_reg.ext_cnt + 8'h01;
            end
            else
            begin
                s_next.ext_req = 1'b1;
            end
        end
        else
        begin
            s_next.ext_cnt = 8'h00;
            s_next.ext_req = 1'b0;
        end
        full_req = por_sync_w | s_reg.ext_req | wdt_sync_w | bod_sync_w
            | dbg_sync_w;
        usb_req = usb_sync_w & s_reg.ctrl[rspc_pkg::CTRL_USB_RST_EN_BIT];
        // Reset release state machine
        case (s_reg.st)
            rspc_pkg::RSPC_ST_HOLD:
            begin
                s_next.core_rst = 1'b1;
                if (!full_req && !usb_req)
                begin
                    s_next.cnt = dly;
                    s_next.st = rspc_pkg::RSPC_ST_COUNT;
                end
            end
            rspc_pkg::RSPC_ST_COUNT:
            begin
                if (full_req || usb_req)
                begin
                    s_next.st = rspc_pkg::RSPC_ST_HOLD;
                end
                else if (s_reg.cnt == 20'h00000)
                begin
                    s_next.core_rst = 1'b0;
                    s_next.usb_rst = 1'b0;
                    s_next.usb_only = 1'b0;
                    s_next.st = rspc_pkg::RSPC_ST_RUN;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt - 20'h00001;
                end
            end
            rspc_pkg::RSPC_ST_RUN:
            begin
                if (full_req || usb_req)
                begin
                    s_next.core_rst = 1'b1;
                    s_next.usb_only = usb_req & ~full_req;
                    s_next.usb_rst = full_req;
                    s_next.st = rspc_pkg::RSPC_ST_HOLD;
                end
            end
            default:
            begin
                s_next.st = rspc_pkg::RSPC_ST_HOLD;
            end
        endcase
        if (full_req)
        begin
            s_next.usb_rst = 1'b1;
            s_next.usb_only = 1'b0;
        end
        // Start at reset vector on the release edge
        s_next.fetch = s_reg.core_rst & ~s_next.core_rst;
        // Register port; internal reset restores initial values, but a USB-only reset keeps the control register's USB reset enable bit
        s_next.rdata = 8'h00;
        if (s_reg.core_rst && !s_reg.usb_only)
        begin
            s_next.ctrl = rspc_pkg::CTRL_RESET;
            s_next.digital_input_disable_0 = rspc_pkg::DIDR_RESET;
            s_next.digital_input_disable_1 = rspc_pkg::DIDR_RESET;
            s_next.sleep = rspc_pkg::SLEEP_RESET;
        end
        else if (s_reg.core_rst)
        begin
            s_next.digital_input_disable_0 = rspc_pkg::DIDR_RESET;
            s_next.digital_input_disable_1 = rspc_pkg::DIDR_RESET;
            s_next.sleep = rspc_pkg::SLEEP_RESET;
            s_next.ctrl = s_reg.ctrl & 8'h01;
        end
        else if (wr_in)
        begin
            case (addr_in)
                rspc_pkg::ADDR_CTRL: s_next.ctrl = wdata_in;
                rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_0: s_next.digital_input_disable_0 = wdata_in;
                rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_1: s_next.digital_input_disable_1 = wdata_in;
                rspc_pkg::ADDR_SLEEP: s_next.sleep = wdata_in[3:0];
                default: s_next.sleep = s_reg.sleep;
            endcase
        end
        else if (rd_in)
        begin
            case (addr_in)
                rspc_pkg::ADDR_CTRL: s_next.rdata = s_reg.ctrl;
                rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_0: s_next.rdata = s_reg.digital_input_disable_0;
                rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_1: s_next.rdata = s_reg.digital_input_disable_1;
                rspc_pkg::ADDR_SLEEP: s_next.rdata = {4'h0, s_reg.sleep};
                rspc_pkg::ADDR_STATUS: s_next.rdata = {3'h0, s_reg.dbg_en, s_reg.vref_en,
                    s_reg.ac_en, s_reg.clk_en, s_reg.usb_only};
                default: s_next.rdata = 8'h00;
            endcase
        end
        // Sleep gating
        asleep = s_reg.sleep[rspc_pkg::SLEEP_ACT_BIT];
        mode = s_reg.sleep[rspc_pkg::SLEEP_MODE_LSB +: 3];
        deep = asleep && (mode != rspc_pkg::RSPC_SM_IDLE) && (mode != rspc_pkg::RSPC_SM_ADCNR);
        s_next.ac_en = s_reg.ctrl[rspc_pkg::CTRL_AC_EN_BIT] & ~deep;
        // Reference is on while brown-out detection, the comparator's reference select or the ADC enable is set, in any sleep mode
        s_next.vref_en = bod_enabled_w | s_reg.ctrl[rspc_pkg::CTRL_ACBG_BIT]
            | s_reg.ctrl[rspc_pkg::CTRL_ADC_EN_BIT];
        s_next.bod_act = bod_enabled_w;
        s_next.wdt_run = wdt_enable_in;
        s_next.dbg_en = onchip_debug_enable_setting_in & debug_port_enable_setting_in
            & ~s_reg.ctrl[rspc_pkg::CTRL_DBG_DIS_BIT];
        s_next.clk_en = ~(deep && (mode != rspc_pkg::RSPC_SM_STBY)
            && (mode != rspc_pkg::RSPC_SM_XSTBY)) | s_reg.dbg_en;
        if (deep)
        begin
            s_next.pin_en = wake_pin_mask_in;
        end
        else
        begin
            s_next.pin_en = 8'hff;
        end
        s_next.ain_en = ~(s_reg.digital_input_disable_0 | s_reg.digital_input_disable_1) & s_next.pin_en;
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_reg <= '0;
            s_reg.st <= rspc_pkg::RSPC_ST_HOLD;
            s_reg.core_rst <= 1'b1;
            s_reg.usb_rst <= 1'b1;
            s_reg.clk_en <= 1'b1;
            s_reg.pin_en <= 8'hff;
            s_reg.ain_en <= 8'hff;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rdata_out = s_reg.rdata;
    assign core_rst_out = s_reg.core_rst;
    assign usb_rst_out = s_reg.usb_rst;
    assign fetch_vector_out = s_reg.fetch;
    assign ac_enable_out = s_reg.ac_en;
    assign vref_enable_out = s_reg.vref_en;
    assign bod_active_out = s_reg.bod_act;
    assign wdt_run_out = s_reg.wdt_run;
    assign main_clk_en_out = s_reg.clk_en;
    assign onchip_debug_system_en_out = s_reg.dbg_en;
    assign pin_ibuf_en_out = s_reg.pin_en;
    assign ain_ibuf_en_out = s_reg.ain_en;
endmodule : rspc_core

// [rspc_core_checker.sv]
// Assertion checker for the reset and sleep power control core
`timescale 1ns/1ps
module rspc_core_checker
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic por_low_in,
    input wire logic ext_rst_n_in,
    input wire logic wdt_expire_in,
    input wire logic wdt_enable_in,
    input wire logic dbg_rst_bit_in,
    input wire logic [2:0] brownout_level_setting_in,
    input wire logic onchip_debug_enable_setting_in,
    input wire logic port_rst_out,
    input wire logic core_rst_out,
    input wire logic fetch_vector_out,
    input wire logic vref_enable_out,
    input wire logic bod_active_out,
    input wire logic wdt_run_out,
    input wire logic main_clk_en_out,
    input wire logic onchip_debug_system_en_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_held;
        core_rst_out [*8];
    endsequence
    sequence s_release;
        ##8 core_rst_out ##[1:14] !core_rst_out;
    endsequence
    property p_port_rst;
        por_low_in || !ext_rst_n_in |=> port_rst_out;
    endproperty
    a_port_rst: assert property (p_port_rst) else $error("port reset missed");
    property p_por_hold;
        $rose(por_low_in) |-> ##[1:4] core_rst_out;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("power-on reset missed");
    property p_stretch;
        $fell(por_low_in) |-> s_held ##0 s_release;
    endproperty
    a_stretch: assert property (p_stretch) else $error("reset stretch wrong");
    property p_wdt_rst;
        wdt_enable_in && wdt_expire_in |-> ##[1:4] core_rst_out;
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missed");
    property p_dbg_rst;
        $rose(dbg_rst_bit_in) |-> ##[1:4] core_rst_out;
    endproperty
    a_dbg_rst: assert property (p_dbg_rst) else $error("debug reset missed");
    property p_fetch;
        $fell(core_rst_out) |-> fetch_vector_out ##1 !fetch_vector_out;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");
    property p_bod_on;
        (brownout_level_setting_in != rspc_pkg::BOD_LEVEL_OFF) [*2] |->
            bod_active_out && vref_enable_out;
    endproperty
    a_bod_on: assert property (p_bod_on) else $error("brown-out not active");
    property p_wdt_run;
        (wdt_enable_in && !core_rst_out) [*2] |-> wdt_run_out;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog stopped");
    property p_dbg_off;
        !onchip_debug_enable_setting_in [*2] |-> !onchip_debug_system_en_out;
    endproperty
    a_dbg_off: assert property (p_dbg_off) else $error("debug not disabled");
    property p_dbg_clk;
        onchip_debug_system_en_out [*2] |-> main_clk_en_out;
    endproperty
    a_dbg_clk: assert property (p_dbg_clk) else $error("main clock off in debug");
endmodule : rspc_core_checker

bind rspc_core rspc_core_checker u_chk (.mclk_in, .rst_in, .por_low_in, .ext_rst_n_in,
    .wdt_expire_in, .wdt_enable_in, .dbg_rst_bit_in, .brownout_level_setting_in,
    .onchip_debug_enable_setting_in, .port_rst_out, .core_rst_out, .fetch_vector_out,
    .vref_enable_out, .bod_active_out, .wdt_run_out, .main_clk_en_out,
    .onchip_debug_system_en_out);

// [rspc_src_model.sv]
// Behavioural model of the reset request sources
`timescale 1ns/1ps
module rspc_src_model
(
    input wire logic mclk_in,
    input wire logic go_in,
    input wire logic [2:0] sel_in,
    output logic por_low_out,
    output logic ext_rst_n_out,
    output logic wdt_expire_out,
    output logic bod_low_out,
    output logic dbg_rst_bit_out,
    output logic usb_eor_out
);
    int cnt = 0;
    logic [2:0] sel_reg = 3'h0;
    logic busy;
    always @(posedge mclk_in)
    begin
        if (go_in && cnt == 0)
        begin
            sel_reg <= sel_in;
            cnt <= (sel_in == 3'h1) ? 110 : (sel_in == 3'h2) ? 1 : 8;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign busy = cnt > 0;
    assign por_low_out = busy && sel_reg == 3'h0;
    assign ext_rst_n_out = !(busy && sel_reg == 3'h1);
    assign wdt_expire_out = busy && sel_reg == 3'h2;
    assign bod_low_out = busy && sel_reg == 3'h3;
    assign dbg_rst_bit_out = busy && sel_reg == 3'h4;
    assign usb_eor_out = busy && sel_reg == 3'h5;
endmodule : rspc_src_model

// [tb_rspc_core.sv]
// Self-checking testbench for the reset and sleep power control core
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rspc_core;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic go = 1'b0;
    logic wdt_enable_in = 1'b0;
    logic onchip_debug_system = 1'b0;
    logic [2:0] src = 3'h0;
    logic [2:0] bod_lvl = 3'h7;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic [7:0] v;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic por_low_in, ext_rst_n_in, wdt_expire_in, bod_low_in, dbg_rst_bit_in, usb_eor_in;
    logic port_rst_out, core_rst_out, usb_rst_out, fetch_vector_out, ac_enable_out;
    logic vref_enable_out, main_clk_en_out, onchip_debug_system_en_out;
    logic [7:0] rdata_out, pin_ibuf_en_out, ain_ibuf_en_out;
    rspc_src_model u_src (.mclk_in, .go_in(go), .sel_in(src), .por_low_out(por_low_in),
        .ext_rst_n_out(ext_rst_n_in), .wdt_expire_out(wdt_expire_in),
        .bod_low_out(bod_low_in), .dbg_rst_bit_out(dbg_rst_bit_in), .usb_eor_out(usb_eor_in));
    rspc_core u_dut (.mclk_in, .rst_in, .por_low_in, .ext_rst_n_in, .wdt_expire_in,
        .wdt_enable_in, .bod_low_in, .dbg_rst_bit_in, .usb_eor_in,
        .brownout_level_setting_in(bod_lvl), .startup_time_select_in(2'h0),
        .clock_source_select_in(4'h0), .onchip_debug_enable_setting_in(onchip_debug_system),
        .debug_port_enable_setting_in(onchip_debug_system), .wake_pin_mask_in(8'h5a), .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .port_rst_out, .core_rst_out, .usb_rst_out,
        .fetch_vector_out, .ac_enable_out, .vref_enable_out, .bod_active_out(),
        .wdt_run_out(), .main_clk_en_out, .onchip_debug_system_en_out, .pin_ibuf_en_out,
        .ain_ibuf_en_out);
    always #2 mclk_in = ~mclk_in;
    task automatic finish_test();
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    task automatic wait_rel();
        for (int n = 0; n < 300 && core_rst_out !== 1'b0; n++)
            @(posedge mclk_in) #1;
        `CHK(fetch_vector_out, 1'b1)
    endtask : wait_rel
    initial
    begin
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1 wait_rel();
        `CHK(ain_ibuf_en_out, 8'hff)
        for (int a = 0; a < 6; a++)
        begin
            rd((a == 5) ? 4'hf : 4'(a), v);
            `CHK(v, (a == 3) ? 8'h02 : 8'h00)
        end
        wr(rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_0, 8'h0f);
        `CHK(ain_ibuf_en_out, 8'hf0)
        wr(rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_1, 8'h3c);
        wr(rspc_pkg::ADDR_STATUS, 8'hff);
        rd(rspc_pkg::ADDR_DIGITAL_INPUT_DISABLE_1, v);
        `CHK(v, 8'h3c)
        rd(rspc_pkg::ADDR_STATUS, v);
        `CHK(v, 8'h02)
        wr(rspc_pkg::ADDR_CTRL, 8'h08);
        for (int m = 0; m < 8; m++)
        begin
            if (m == 4 || m == 5)
                continue;
            wr(rspc_pkg::ADDR_SLEEP, {4'h0, 3'(m), 1'b1});
            `CHK(ac_enable_out, 1'(m < 2))
            `CHK(pin_ibuf_en_out, (m > 1) ? 8'h5a : 8'hff)
            `CHK(main_clk_en_out, 1'(m != 2 && m != 3))
        end
        onchip_debug_system <= 1'b1;
        wr(rspc_pkg::ADDR_SLEEP, 8'h05);
        `CHK(main_clk_en_out, 1'b1)
        `CHK(onchip_debug_system_en_out, 1'b1)
        wr(rspc_pkg::ADDR_CTRL, 8'h80);
        `CHK(onchip_debug_system_en_out, 1'b0)
        wr(rspc_pkg::ADDR_SLEEP, 8'h00);
        foreach (v[i])
        begin
            if (i > 2)
                continue;
            wr(rspc_pkg::ADDR_CTRL, (i == 2) ? 8'h00 : (i == 1) ? 8'h04 : 8'h02);
            `CHK(vref_enable_out, 1'(i != 2))
        end
        for (int s = 0; s < 8; s++)
        begin
            wdt_enable_in <= (s == 2);
            bod_lvl <= (s == 3) ? 3'h4 : 3'h7;
            wr(rspc_pkg::ADDR_CTRL, (s == 5) ? 8'h01 : 8'h08);
            @(posedge mclk_in);
            go <= 1'b1;
            src <= (s > 5) ? 3'(s - 4) : 3'(s);
            wdt_enable_in <= (s == 2);
            @(posedge mclk_in);
            go <= 1'b0;
            for (int n = 0; n < 120 && core_rst_out !== 1'b1; n++)
                @(posedge mclk_in) #1;
            if (s > 5)
            begin
                `CHK(core_rst_out, 1'b0)
                continue;
            end
            `CHK(core_rst_out, 1'b1)
            if (s != 2 && s != 5)
                `CHK(port_rst_out, 1'b1)
            if (s == 5)
                `CHK(usb_rst_out, 1'b0)
            wait_rel();
            rd(rspc_pkg::ADDR_CTRL, v);
            `CHK(v, (s == 5) ? 8'h01 : 8'h00)
        end
        finish_test();
    end
endmodule : tb_rspc_core
